/* rtl/sctrv_device.sv */
// Purpose: read-only register view of the second safe channel
// Assumes: frame, sync and validity pulses come from mclk logic
// Notes:   position bytes read from a snapshot taken at status read
//
// Contract
// - version byte mirrors shared version register
// - arrangement code read-only, writes ignored
// - code 02h/22h means copy of primary
// - code 03h/33h means separate secondary sensor
// - toggle bit alternates per transfer, starts 0
// - reader rejects position if toggle unchanged
// - test bit set if test during transfer
// - reader trusts test bit only after requesting
// - reader sees test via error bit or crc
// - error bit shows last position invalid
// - low status bits always 11100, else error; status reads 00h until the first transfer
// - summary bit of status driven out
// - update once per eight frames, if valid
// - position belongs to one of last eight syncs
// - secondary is complement of primary position, or of sensor position for 03h/33h
// - five read-only position bytes 19h..1Dh
// - crc high 1Eh, low 1Fh, reset zero
// - position forty bits, complemented form
// - crc C86Ch, init 0, xor 00FFh
`timescale 1ns/1ps
`default_nettype none
module sctrv_device
	import sctrv_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst,
	sctrv_if.dev                   bus,
	input  wire logic [DATA_W-1:0] versionCode,
	input  wire logic [DATA_W-1:0] arrangeStrap,
	input  wire logic              frameStrobe,
	input  wire logic              syncPulse,
	input  wire logic              xferValid,
	input  wire logic [POS_W-1:0]  primaryPos,
	input  wire logic [POS_W-1:0]  sensorPos,
	input  wire logic              testDone,
	input  wire logic              posFault,
	output logic                   statusSummary,
	output logic                   sameAsPrimary,
	output logic                   separateSensor
);
	logic [DATA_W-1:0]      arrange_r;
	logic                   strapTaken_r;
	logic [FRAME_CNT_W-1:0] frameCnt_r;
	logic [POS_W-1:0]       sample_r;
	logic                   testSeen_r;
	logic                   toggle_r;
	logic [DATA_W-1:0]      status_r;
	logic [POS_W-1:0]       pos_r;
	logic [CRC_W-1:0]       crc_r;
	logic [POS_W-1:0]       snapPos_r;
	logic [CRC_W-1:0]       snapCrc_r;
	logic [DATA_W-1:0]      rdData_r;
	logic                   rdAck_r;

	logic                   isSame;
	logic                   isSeparate;
	logic [POS_W-1:0]       srcPos;
	logic                   slotEnd;
	logic                   commit;
	logic                   firstSync;
	logic                   testNow;
	logic [DATA_W-1:0]      status_nxt;
	logic [POS_W-1:0]       pos_nxt;
	logic [CRC_W-1:0]       crc_nxt;
	logic                   readStatus;
	logic [DATA_W-1:0]      rdData_nxt;

	// arrangement code decode
	assign isSame     = (arrange_r == ARR_SAME_A)
	                  | (arrange_r == ARR_SAME_B);
	assign isSeparate = (arrange_r == ARR_SEP_A)
	                  | (arrange_r == ARR_SEP_B);
	assign sameAsPrimary  = isSame;
	assign separateSensor = isSeparate;

	// separate sensor only when the code says so; else mirror primary
	assign srcPos = isSeparate ? sensorPos : primaryPos;

	// frame slot handling
	assign slotEnd   = frameStrobe & (frameCnt_r == LAST_FRAME);
	assign commit    = slotEnd & xferValid;
	assign firstSync = syncPulse & (frameCnt_r == FIRST_FRAME);
	assign testNow   = testSeen_r | testDone;

	// status byte assembled from live flags
	assign status_nxt = {toggle_r,
	                     testNow,
	                     posFault,
	                     FIXED_PATTERN};
	assign pos_nxt = ~sample_r;
	assign crc_nxt = crc_calc(status_nxt, pos_nxt);

	// summary: any fault indication in the presented status
	assign statusSummary = status_r[BIT_ERR]
	    | (status_r[FIX_MSB:0] != FIXED_PATTERN);

	// read decode; writes never reach any storage
	assign readStatus = bus.rdEn & (bus.addr == OFS_STATUS);

	always_comb begin
		rdData_nxt = RST_BYTE;
		unique case (bus.addr)
			OFS_VERSION: begin
				rdData_nxt = versionCode;
			end
			OFS_ARRANGE: begin
				rdData_nxt = arrange_r;
			end
			OFS_STATUS: begin
				rdData_nxt = status_r;
			end
			OFS_POS4: begin
				rdData_nxt = snapPos_r[39:32];
			end
			OFS_POS3: begin
				rdData_nxt = snapPos_r[31:24];
			end
			OFS_POS2: begin
				rdData_nxt = snapPos_r[23:16];
			end
			OFS_POS1: begin
				rdData_nxt = snapPos_r[15:8];
			end
			OFS_POS0: begin
				rdData_nxt = snapPos_r[7:0];
			end
			OFS_CRC_HI: begin
				rdData_nxt = snapCrc_r[15:8];
			end
			OFS_CRC_LO: begin
				rdData_nxt = snapCrc_r[7:0];
			end
			OFS_PLACE: begin
				rdData_nxt = RST_BYTE;
			end
			default: begin
				rdData_nxt = RST_BYTE;
			end
		endcase
	end

	// strap is caught once after reset release, never under reset
	always_ff @(posedge mclk) begin
		if (rst) begin
			arrange_r    <= RST_BYTE;
			strapTaken_r <= 1'b0;
		end else if (!strapTaken_r) begin
			arrange_r    <= arrangeStrap;
			strapTaken_r <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			frameCnt_r <= FIRST_FRAME;
		end else if (frameStrobe) begin
			frameCnt_r <= frameCnt_r + 3'h1;
		end
	end

	// sample at the first sync of the slot; the committed value is
	// therefore up to eight frames old, never newer than that sync
	always_ff @(posedge mclk) begin
		if (rst) begin
			sample_r <= '0;
		end else if (firstSync) begin
			sample_r <= srcPos;
		end
	end

	// test seen anywhere in the slot; a test in the commit cycle wins
	always_ff @(posedge mclk) begin
		if (rst) begin
			testSeen_r <= 1'b0;
		end else if (testDone) begin
			testSeen_r <= ~slotEnd;
		end else if (slotEnd) begin
			testSeen_r <= 1'b0;
		end
	end

	// status, position and crc move in one edge
	always_ff @(posedge mclk) begin
		if (rst) begin
			toggle_r <= 1'b0;
			status_r <= RST_BYTE;
			pos_r    <= '0;
			crc_r    <= CRC_INIT;
		end else if (commit) begin
			toggle_r <= ~toggle_r;
			status_r <= status_nxt;
			pos_r    <= pos_nxt;
			crc_r    <= crc_nxt;
		end
	end

	// snapshot keeps a status-first read sequence on one transfer
	always_ff @(posedge mclk) begin
		if (rst) begin
			snapPos_r <= '0;
			snapCrc_r <= CRC_INIT;
		end else if (readStatus) begin
			snapPos_r <= pos_r;
			snapCrc_r <= crc_r;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rdData_r <= RST_BYTE;
			rdAck_r  <= 1'b0;
		end else begin
			rdAck_r <= bus.rdEn;
			if (bus.rdEn) begin
				rdData_r <= rdData_nxt;
			end
		end
	end

	assign bus.rdData = rdData_r;
	assign bus.rdAck  = rdAck_r;
endmodule
`default_nettype wire

/* rtl/sctrv_host.sv */
// Purpose: safety reader fetching and checking channel-two data
// Assumes: device answers each read one cycle later
// Notes:   reads status first so the device snapshots the rest;
//          ends with version, code and spare slot reads
`timescale 1ns/1ps
`default_nettype none
module sctrv_host
	import sctrv_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst,
	sctrv_if.host                  bus,
	input  wire logic              fetchStart,
	input  wire logic              testRequested,
	output logic                   fetchDone,
	output logic [POS_W-1:0]       posOut,
	output logic                   posGood,
	output logic                   chanError,
	output logic                   testDetected,
	output logic                   busy
);
	typedef enum {S_IDLE, S_REQ, S_WAIT, S_CHECK} sctrv_state_e;

	sctrv_state_e      state_r;
	logic [3:0]        idx_r;
	logic [DATA_W-1:0] status_r;
	logic [POS_W-1:0]  pos_r;
	logic [CRC_W-1:0]  crc_r;
	logic              prevTog_r;
	logic              done_r;
	logic [POS_W-1:0]  posOut_r;
	logic              good_r;
	logic              err_r;
	logic              testDet_r;

	logic              togChanged;
	logic              fixOk;
	logic              crcOk;
	logic              fault;

	assign togChanged = status_r[BIT_TOGGLE] != prevTog_r;
	assign fixOk = status_r[FIX_MSB:0] == FIXED_PATTERN;
	assign crcOk = crc_calc(status_r, pos_r) == crc_r;
	assign fault = status_r[BIT_ERR] | ~crcOk | ~fixOk;

	assign bus.rdEn   = (state_r == S_REQ);
	assign bus.wrEn   = 1'b0;
	assign bus.wrData = RST_BYTE;
	// tail reads touch version, code and the spare slot
	assign bus.addr   = (idx_r == 4'h8) ? OFS_VERSION
	                  : (idx_r == 4'h9) ? OFS_ARRANGE
	                  : (idx_r == 4'hA) ? OFS_PLACE
	                  : OFS_STATUS + {2'h0, idx_r};
	assign busy       = (state_r != S_IDLE);

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_r   <= S_IDLE;
			idx_r     <= 4'h0;
			status_r  <= RST_BYTE;
			pos_r     <= '0;
			crc_r     <= CRC_INIT;
			prevTog_r <= 1'b1;
			done_r    <= 1'b0;
			posOut_r  <= '0;
			good_r    <= 1'b0;
			err_r     <= 1'b0;
			testDet_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			unique case (state_r)
				S_IDLE: begin
					idx_r <= 4'h0;
					if (fetchStart) begin
						state_r <= S_REQ;
					end
				end
				S_REQ: begin
					state_r <= S_WAIT;
				end
				S_WAIT: begin
					if (bus.rdAck) begin
						unique case (idx_r)
							4'h0: status_r <= bus.rdData;
							4'h1, 4'h2, 4'h3, 4'h4, 4'h5: begin
								pos_r <= {pos_r[31:0], bus.rdData};
							end
							4'h6: crc_r[15:8] <= bus.rdData;
							4'h7: crc_r[7:0] <= bus.rdData;
							default: begin
							end
						endcase
						idx_r   <= idx_r + 4'h1;
						state_r <= (idx_r == READ_LAST) ? S_CHECK : S_REQ;
					end
				end
				S_CHECK: begin
					// first transfer is accepted against toggle 1
					good_r    <= togChanged & ~fault;
					err_r     <= ~fixOk | ~togChanged;
					testDet_r <= testRequested & fault
					           & status_r[BIT_TEST];
					posOut_r  <= pos_r;
					// a broken pattern is no transfer; keep the old toggle
					if (fixOk) begin
						prevTog_r <= status_r[BIT_TOGGLE];
					end
					done_r    <= 1'b1;
					state_r   <= S_IDLE;
				end
			endcase
		end
	end

	assign fetchDone    = done_r;
	assign posOut       = posOut_r;
	assign posGood      = good_r;
	assign chanError    = err_r;
	assign testDetected = testDet_r;
endmodule
`default_nettype wire

/* rtl/sctrv_if.sv */
// Purpose: byte register path between view and safety reader
// Assumes: one clock, reader holds one request per pulse
// Notes:   no clocking block; the bench joins both ends
`timescale 1ns/1ps
`default_nettype none
interface sctrv_if;
	import sctrv_pkg::*;
	logic              rdEn;
	logic              wrEn;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wrData;
	logic [DATA_W-1:0] rdData;
	logic              rdAck;

	modport dev (
		input  rdEn,
		input  wrEn,
		input  addr,
		input  wrData,
		output rdData,
		output rdAck
	);
	modport host (
		output rdEn,
		output wrEn,
		output addr,
		output wrData,
		input  rdData,
		input  rdAck
	);
endinterface
`default_nettype wire

/* rtl/sctrv_pkg.sv */
// Purpose: shared constants and crc function for the channel-two view
// Assumes: byte-wide register space, 6-bit addresses
// Notes:   crc runs msb first over status then position bytes
`default_nettype none
package sctrv_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int POS_W  = 40;
	localparam int CRC_W  = 16;
	localparam int FRAME_CNT_W = 3;

	localparam logic [ADDR_W-1:0] OFS_VERSION  = 6'h0B;
	localparam logic [ADDR_W-1:0] OFS_ARRANGE  = 6'h0F;
	localparam logic [ADDR_W-1:0] OFS_STATUS   = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_POS4     = 6'h19;
	localparam logic [ADDR_W-1:0] OFS_POS3     = 6'h1A;
	localparam logic [ADDR_W-1:0] OFS_POS2     = 6'h1B;
	localparam logic [ADDR_W-1:0] OFS_POS1     = 6'h1C;
	localparam logic [ADDR_W-1:0] OFS_POS0     = 6'h1D;
	localparam logic [ADDR_W-1:0] OFS_CRC_HI   = 6'h1E;
	localparam logic [ADDR_W-1:0] OFS_CRC_LO   = 6'h1F;
	localparam logic [ADDR_W-1:0] OFS_PLACE    = 6'h3F;

	localparam int BIT_TOGGLE = 7;
	localparam int BIT_TEST   = 6;
	localparam int BIT_ERR    = 5;
	localparam int FIX_MSB    = 4;
	localparam logic [4:0] FIXED_PATTERN = 5'h1C;

	localparam logic [DATA_W-1:0] RST_BYTE     = 8'h00;
	localparam logic [DATA_W-1:0] ARR_SAME_A   = 8'h02;
	localparam logic [DATA_W-1:0] ARR_SAME_B   = 8'h22;
	localparam logic [DATA_W-1:0] ARR_SEP_A    = 8'h03;
	localparam logic [DATA_W-1:0] ARR_SEP_B    = 8'h33;
	localparam logic [FRAME_CNT_W-1:0] LAST_FRAME = 3'h7;
	localparam logic [FRAME_CNT_W-1:0] FIRST_FRAME = 3'h0;

	localparam logic [CRC_W-1:0] CRC_KOOPMAN = 16'hC86C;
	localparam logic [CRC_W-1:0] CRC_POLY    = {CRC_KOOPMAN[14:0], 1'b1};
	localparam logic [CRC_W-1:0] CRC_INIT    = 16'h0000;
	localparam logic [CRC_W-1:0] CRC_XOROUT  = 16'h00FF;
	localparam int CRC_MSG_W = DATA_W + POS_W;
	localparam logic [3:0] READ_LAST = 4'hA;

	function automatic logic [CRC_W-1:0] crc_calc(
		input logic [DATA_W-1:0] status,
		input logic [POS_W-1:0]  pos
	);
		logic [CRC_MSG_W-1:0] msg;
		logic [CRC_W-1:0]     c;
		logic                 fb;
		msg = {status, pos};
		c = CRC_INIT;
		for (int i = CRC_MSG_W - 1; i >= 0; i--) begin
			fb = c[CRC_W-1] ^ msg[i];
			c = {c[CRC_W-2:0], 1'b0};
			if (fb) begin
				c = c ^ CRC_POLY;
			end
		end
		return c ^ CRC_XOROUT;
	endfunction
endpackage
`default_nettype wire

/* verif/sctrv_asserts.sv */
// Purpose: bus checks between reader and channel-two view
// Assumes: one clock, synchronous active high reset
// Notes:   sees the interface signals only
`timescale 1ns/1ps
`default_nettype none
module sctrv_asserts
	import sctrv_pkg::*;
(
	input wire logic              mclk,
	input wire logic              rst,
	input wire logic              rdEn,
	input wire logic              wrEn,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wrData,
	input wire logic [DATA_W-1:0] rdData,
	input wire logic              rdAck
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	wire logic stRd = rdEn && addr == OFS_STATUS;
	wire logic lastPos = rdEn && addr == OFS_POS0;

	ack_timing_a: assert property (rdEn |=> rdAck)
		else $error("read not answered in one cycle");
	ack_cause_a: assert property (rdAck |-> $past(rdEn))
		else $error("answer without a request");
	fix_bits_a: assert property (stRd |=>
		rdData == RST_BYTE || rdData[FIX_MSB:0] == FIXED_PATTERN)
		else $error("status low bits not fixed pattern");
	no_write_a: assert property (!wrEn)
		else $error("write issued to read-only view");
	data_hold_a: assert property (!rdAck |-> $stable(rdData))
		else $error("read data moved without an answer");
	pos_order_a: assert property (stRd |-> ##2
		(rdEn && addr == OFS_POS4))
		else $error("position read does not follow status");
	crc_order_a: assert property (lastPos |-> ##2
		(rdEn && addr == OFS_CRC_HI) ##2 (rdEn && addr == OFS_CRC_LO))
		else $error("checksum bytes out of order");
	read_gap_a: assert property (rdEn |=> !rdEn)
		else $error("reader issued back to back reads");
	addr_range_a: assert property (rdEn |->
		(addr >= OFS_STATUS && addr <= OFS_CRC_LO) || addr == OFS_VERSION
		|| addr == OFS_ARRANGE || addr == OFS_PLACE)
		else $error("reader address outside channel block");
	tail_order_a: assert property (rdEn && addr == OFS_CRC_LO |->
		##2 (rdEn && addr == OFS_VERSION) ##2 (rdEn && addr == OFS_ARRANGE)
		##2 (rdEn && addr == OFS_PLACE))
		else $error("tail reads out of order");
	place_zero_a: assert property (rdEn && addr == OFS_PLACE |=>
		rdData == RST_BYTE)
		else $error("spare slot did not read zero");

	cover property (stRd);
	cover property (rdAck && rdData[BIT_TOGGLE]);
	cover property (rdAck && rdData[BIT_ERR]);
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Purpose: joins reader and view, drives frames, judges results
// Assumes: inputs change on the falling edge
// Notes:   bus bytes are sniffed to check checksum independently
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sctrv_pkg::*;
	logic        mclk, rst, frameStrobe, syncPulse, xferValid;
	logic        testDone, posFault, fetchStart, testRequested;
	logic [7:0]  arrangeStrap, expSt, lastA, versionCode;
	logic [39:0] primaryPos, sensorPos, posOut, expPos;
	logic        statusSummary, sameAsPrimary, separateSensor;
	logic        fetchDone, posGood, chanError, testDetected;
	logic        expTog, sepMode;
	logic [7:0]  rb [64];
	int          numErrors, samplesChecked;

	sctrv_if u_sctrv_if ();
	sctrv_device u_sctrv_device (.mclk(mclk), .rst(rst),
		.bus(u_sctrv_if.dev), .versionCode(versionCode),
		.arrangeStrap(arrangeStrap), .frameStrobe(frameStrobe),
		.syncPulse(syncPulse), .xferValid(xferValid),
		.primaryPos(primaryPos), .sensorPos(sensorPos),
		.testDone(testDone), .posFault(posFault),
		.statusSummary(statusSummary), .sameAsPrimary(sameAsPrimary),
		.separateSensor(separateSensor));
	sctrv_host u_sctrv_host (.mclk(mclk), .rst(rst),
		.bus(u_sctrv_if.host), .fetchStart(fetchStart),
		.testRequested(testRequested), .fetchDone(fetchDone),
		.posOut(posOut), .posGood(posGood), .chanError(chanError),
		.testDetected(testDetected), .busy());
	sctrv_asserts u_chk (.mclk(mclk), .rst(rst),
		.rdEn(u_sctrv_if.rdEn), .wrEn(u_sctrv_if.wrEn),
		.addr(u_sctrv_if.addr), .wrData(u_sctrv_if.wrData),
		.rdData(u_sctrv_if.rdData), .rdAck(u_sctrv_if.rdAck));

	always #2.5 mclk = ~mclk;

	// host never overlaps reads, so one held address is enough
	always @(posedge mclk) begin
		if (u_sctrv_if.rdEn) begin
			lastA <= {2'h0, u_sctrv_if.addr};
		end
		if (u_sctrv_if.rdAck) begin
			rb[lastA[5:0]] <= u_sctrv_if.rdData;
		end
	end

	function automatic logic [15:0] crc16(input logic [47:0] m);
		logic [15:0] c;
		c = 16'h0000;
		for (int i = 47; i >= 0; i--) begin
			c = {c[14:0], 1'b0} ^ ((c[15] ^ m[i]) ? 16'h90D9 : 16'h0000);
		end
		return c ^ 16'h00FF;
	endfunction

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			numErrors++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("checked %0d mismatches %0d", samplesChecked, numErrors);
		if (numErrors == 0 && samplesChecked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic do_reset(input logic [7:0] code);
		arrangeStrap = code;
		rst = 1'b1;
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		@(negedge mclk);
		expTog = 1'b0;
		expSt = 8'h00;
		expPos = 40'h0;
		sepMode = code == 8'h03 || code == 8'h33;
	endtask

	task automatic commit(input logic ok, input logic tst,
		input logic flt, input logic [39:0] pp, input logic [39:0] sp);
		primaryPos = pp;
		sensorPos = sp;
		syncPulse = 1'b1;
		@(negedge mclk);
		syncPulse = 1'b0;
		for (int i = 0; i < 8; i++) begin
			frameStrobe = 1'b1;
			xferValid = ok && i == 7;
			testDone = tst && i == 3;
			posFault = flt;
			@(negedge mclk);
			frameStrobe = 1'b0;
			testDone = 1'b0;
			@(negedge mclk);
		end
		if (ok) begin
			expSt = {expTog, tst, flt, 5'h1C};
			expPos = sepMode ? ~sp : ~pp;
			expTog = ~expTog;
		end
	endtask

	task automatic fetch(input logic good, input logic err);
		int n;
		fetchStart = 1'b1;
		@(negedge mclk);
		fetchStart = 1'b0;
		n = 0;
		while (fetchDone !== 1'b1 && n < 40) begin
			@(negedge mclk);
			n++;
		end
		chk(n < 40, 1);
		chk(rb[OFS_STATUS], expSt);
		chk({rb[OFS_POS4], rb[OFS_POS3], rb[OFS_POS2], rb[OFS_POS1],
			rb[OFS_POS0]}, expPos);
		chk({rb[OFS_CRC_HI], rb[OFS_CRC_LO]}, expSt == 8'h00 ? 16'h0 :
			crc16({expSt, expPos}));
		chk(rb[OFS_VERSION], versionCode);
		chk(rb[OFS_ARRANGE], arrangeStrap);
		chk(rb[OFS_PLACE], 8'h00);
		chk(posOut, expPos);
		chk(posGood, good);
		chk(chanError, err);
		chk(statusSummary, expSt[5] | (expSt[4:0] != 5'h1C));
	endtask

	task automatic t_codes();
		logic [7:0] codes [4] = '{8'h02, 8'h22, 8'h03, 8'h33};
		foreach (codes[i]) begin
			do_reset(codes[i]);
			chk(sameAsPrimary, i < 2);
			chk(separateSensor, i >= 2);
		end
		$display("done codes");
	endtask

	task automatic t_flow();
		do_reset(ARR_SAME_A);
		fetch(1'b0, 1'b1);
		commit(1'b1, 1'b0, 1'b0, 40'h12_3456_789A, 40'h0);
		fetch(1'b1, 1'b0);
		commit(1'b1, 1'b0, 1'b0, 40'hFE_DCBA_9876, 40'h0);
		fetch(1'b1, 1'b0);
		commit(1'b0, 1'b0, 1'b0, 40'h55_AA55_AA55, 40'h0);
		fetch(1'b0, 1'b1);
		testRequested = 1'b1;
		commit(1'b1, 1'b1, 1'b1, 40'h00_0000_0001, 40'h0);
		fetch(1'b0, 1'b0);
		chk(testDetected, 1'b1);
		testRequested = 1'b0;
		$display("done flow");
	endtask

	task automatic t_sensor();
		do_reset(ARR_SEP_B);
		// version is live; a new value must show on the next read
		versionCode = 8'hA5;
		commit(1'b1, 1'b0, 1'b0, 40'h11_1111_1111, 40'hC3_0F0F_3CA5);
		fetch(1'b1, 1'b0);
		$display("done sensor");
	endtask

	initial begin
		mclk = 1'b0;
		{rst, frameStrobe, syncPulse, xferValid, testDone} = '0;
		{posFault, fetchStart, testRequested} = '0;
		{arrangeStrap, primaryPos, sensorPos} = '0;
		versionCode = 8'h5A; // arbitrary value
		numErrors = 0;
		samplesChecked = 0;
		t_codes();
		t_flow();
		t_sensor();
		test_done();
	end

	initial begin
		#100000;
		numErrors++;
		test_done();
	end
endmodule
`default_nettype wire
